// ===== verilog/rxe_pkg.sv
// Shared constants for the receive event signalling block and its host.
package rxe_pkg;

  // ==========================================================================
  // Widths and sizes
  // ==========================================================================
  localparam int          CHANNELS   = 2;
  localparam int          ADDR_W     = 5;
  localparam int          DATA_W     = 8;
  localparam int          QUEUE_AW   = 4;
  localparam int          PTR_W      = QUEUE_AW + 1;
  localparam logic [4:0]  QUEUE_DEPTH = 5'h10;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [4:0] ADDR_QUEUE_A   = 5'h00;
  localparam logic [4:0] ADDR_QUEUE_B   = 5'h01;
  localparam logic [4:0] ADDR_EVENT     = 5'h02;
  localparam logic [4:0] ADDR_IRQ_EN    = 5'h03;
  localparam logic [4:0] ADDR_PIN_EN    = 5'h04;
  localparam logic [4:0] ADDR_CFG       = 5'h05;
  localparam logic [4:0] ADDR_LEVEL_A   = 5'h06;
  localparam logic [4:0] ADDR_LEVEL_B   = 5'h07;
  localparam logic [4:0] ADDR_BLANK     = 5'h10;
  localparam logic [4:0] ADDR_REVISION  = 5'h1f;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         EVT_READY_LSB  = 0;
  localparam int         EVT_FAULT_LSB  = 2;
  localparam logic [3:0] IRQ_EN_RESET   = 4'h0;
  localparam logic [3:0] PIN_EN_RESET   = 4'h0;
  localparam logic [1:0] CFG_RESET      = 2'h0;
  localparam logic [7:0] BLANK_RESET    = 8'h37;
  // Revision code value is arbitrary.
  localparam logic [3:0] REVISION_CODE  = 4'h5;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam logic [7:0] BLANK_MIN_MS   = 8'h37;

endpackage

// ===== verilog/rxe_link_if.sv
// Register access and event pins between the host and the device end.
`timescale 1ns/1ps
interface rxe_link_if;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic       reg_wr;
  logic [7:0] reg_rdata;
  logic       reg_ack;
  logic       irq;
  logic [1:0] rdy_pin;
  logic [1:0] flt_pin;

  modport dev (
    input  reg_addr,
    input  reg_wdata,
    input  reg_rd,
    input  reg_wr,
    output reg_rdata,
    output reg_ack,
    output irq,
    output rdy_pin,
    output flt_pin
  );

  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_rd,
    output reg_wr,
    input  reg_rdata,
    input  reg_ack,
    input  irq,
    input  rdy_pin,
    input  flt_pin
  );
endinterface

// ===== verilog/rxe_device.sv
// Device end: receive queues, event flags, interrupt, pins and revision.
`timescale 1ns/1ps

// Functional notes
// - Read-only revision register, fixed low nibble
// - Revision upper four bits read zero
// - Host reads revision only during initialisation
// - Clean message sets ready flag, interrupt
// - Enabled ready pin follows ready flag
// - Reading message out clears flag, pin
// - Bad or late message raises fault
// - Optional discard of bad messages
// - Host intervenes only when message ready; enabled fault flags also raise the interrupt
// - Blanking time programmed at least 55ms
module rxe_device
  import rxe_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  rxe_link_if.dev               link,
  input  wire logic [1:0]       rx_byte_valid_i,
  input  wire logic [1:0][7:0]  rx_byte_i,
  input  wire logic [1:0]       rx_msg_end_i,
  input  wire logic [1:0]       rx_msg_err_i,
  input  wire logic [1:0]       rx_late_i,
  output logic      [1:0]       rx_full_o,
  output logic      [7:0]       blank_ms_o
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0]            mem [CHANNELS][QUEUE_DEPTH];
  logic [1:0][PTR_W-1:0] wptr_reg;
  logic [1:0][PTR_W-1:0] commit_reg;
  logic [1:0][PTR_W-1:0] rptr_reg;
  logic [1:0][PTR_W-1:0] avail;
  logic [1:0][PTR_W-1:0] used;
  logic [1:0]            push;
  logic [1:0]            pop;
  logic [1:0]            drop_msg;
  logic [1:0]            ready_reg;
  logic [1:0]            ready_next;
  logic [1:0]            fault_reg;
  logic [1:0]            fault_next;
  logic [3:0]            irq_en_reg;
  logic [3:0]            pin_en_reg;
  logic [1:0]            cfg_discard_reg;
  logic [7:0]            blank_reg;
  logic [7:0]            rdata_reg;
  logic                  ack_reg;
  logic                  irq_reg;
  logic [1:0]            rdy_pin_reg;
  logic [1:0]            flt_pin_reg;
  logic [1:0]            full_reg;
  logic [7:0]            read_val;
  logic                  rd_event;

  // ==========================================================================
  // Queue bookkeeping
  // ==========================================================================
  assign rd_event = link.reg_rd && (link.reg_addr == ADDR_EVENT);

  genvar c;
  for (c = 0; c < CHANNELS; c++) begin : g_ch
    logic [4:0] qaddr;
    assign qaddr       = (c == 0) ? ADDR_QUEUE_A : ADDR_QUEUE_B;
    assign avail[c]    = commit_reg[c] - rptr_reg[c];
    assign used[c]     = wptr_reg[c] - rptr_reg[c];
    assign push[c]     = rx_byte_valid_i[c] && (used[c] != QUEUE_DEPTH);
    assign pop[c]      = link.reg_rd && (link.reg_addr == qaddr) &&
                         (avail[c] != '0);
    assign drop_msg[c] = cfg_discard_reg[c] &&
                         ((rx_msg_end_i[c] && rx_msg_err_i[c]) ||
                          rx_late_i[c]);

    assign ready_next[c] = (rx_msg_end_i[c] && !rx_msg_err_i[c]) ||
                           (ready_reg[c] &&
                            !(pop[c] && (avail[c] == 5'h01)));

    assign fault_next[c] = (rx_msg_end_i[c] && rx_msg_err_i[c]) ||
                           rx_late_i[c] ||
                           (fault_reg[c] && !rd_event);

    always_ff @(posedge ref_clk_i) begin
      if (push[c] && !drop_msg[c]) begin
        mem[c][wptr_reg[c][QUEUE_AW-1:0]] <= rx_byte_i[c];
      end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        wptr_reg[c]   <= '0;
        commit_reg[c] <= '0;
      end else if (drop_msg[c]) begin
        wptr_reg[c]   <= commit_reg[c];
      end else begin
        if (push[c]) begin
          wptr_reg[c] <= wptr_reg[c] + 5'h01;
        end
        if (rx_msg_end_i[c] || rx_late_i[c]) begin
          commit_reg[c] <= push[c] ? wptr_reg[c] + 5'h01 : wptr_reg[c];
        end
      end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        rptr_reg[c] <= '0;
      end else if (pop[c]) begin
        rptr_reg[c] <= rptr_reg[c] + 5'h01;
      end
    end
  end

  // ==========================================================================
  // Event flags
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_reg <= '0;
      fault_reg <= '0;
    end else begin
      ready_reg <= ready_next;
      fault_reg <= fault_next;
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_en_reg      <= IRQ_EN_RESET;
      pin_en_reg      <= PIN_EN_RESET;
      cfg_discard_reg <= CFG_RESET;
      blank_reg       <= BLANK_RESET;
    end else if (link.reg_wr) begin
      unique case (link.reg_addr)
        ADDR_IRQ_EN: begin
          irq_en_reg <= link.reg_wdata[3:0];
        end
        ADDR_PIN_EN: begin
          pin_en_reg <= link.reg_wdata[3:0];
        end
        ADDR_CFG: begin
          cfg_discard_reg <= link.reg_wdata[1:0];
        end
        ADDR_BLANK: begin
          blank_reg <= link.reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    read_val = 8'h00;
    unique case (link.reg_addr)
      ADDR_QUEUE_A: begin
        read_val = (avail[0] != '0) ? mem[0][rptr_reg[0][QUEUE_AW-1:0]]
                                    : 8'h00;
      end
      ADDR_QUEUE_B: begin
        read_val = (avail[1] != '0) ? mem[1][rptr_reg[1][QUEUE_AW-1:0]]
                                    : 8'h00;
      end
      ADDR_EVENT: begin
        read_val = {4'h0, fault_reg, ready_reg};
      end
      ADDR_IRQ_EN: begin
        read_val = {4'h0, irq_en_reg};
      end
      ADDR_PIN_EN: begin
        read_val = {4'h0, pin_en_reg};
      end
      ADDR_CFG: begin
        read_val = {6'h00, cfg_discard_reg};
      end
      ADDR_LEVEL_A: begin
        read_val = {3'h0, avail[0]};
      end
      ADDR_LEVEL_B: begin
        read_val = {3'h0, avail[1]};
      end
      ADDR_BLANK: begin
        read_val = blank_reg;
      end
      ADDR_REVISION: begin
        read_val = {4'h0, REVISION_CODE};
      end
      default: begin
        read_val = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= 8'h00;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= link.reg_rd || link.reg_wr;
      if (link.reg_rd) begin
        rdata_reg <= read_val;
      end
    end
  end

  // ==========================================================================
  // Interrupt and pins
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg     <= 1'b0;
      rdy_pin_reg <= '0;
      flt_pin_reg <= '0;
    end else begin
      irq_reg     <= |({fault_next, ready_next} & irq_en_reg);
      rdy_pin_reg <= ready_next & pin_en_reg[1:0];
      flt_pin_reg <= fault_next & pin_en_reg[3:2];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      full_reg <= '0;
    end else begin
      full_reg[0] <= (used[0] + {4'h0, push[0]} - {4'h0, pop[0]})
                     == QUEUE_DEPTH;
      full_reg[1] <= (used[1] + {4'h0, push[1]} - {4'h0, pop[1]})
                     == QUEUE_DEPTH;
    end
  end

  assign link.reg_rdata = rdata_reg;
  assign link.reg_ack   = ack_reg;
  assign link.irq       = irq_reg;
  assign link.rdy_pin   = rdy_pin_reg;
  assign link.flt_pin   = flt_pin_reg;
  assign rx_full_o      = full_reg;
  assign blank_ms_o     = blank_reg;

endmodule

// ===== verilog/rxe_host.sv
// Host end: one register access at a time, event pins mirrored.
`timescale 1ns/1ps
module rxe_host
  import rxe_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  rxe_link_if.host        link,
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [4:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  input  wire logic       link_active_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic      [7:0] rsp_data_o,
  output logic            rsp_refused_o,
  output logic            irq_o,
  output logic      [1:0] rx_ready_o,
  output logic      [1:0] rx_fault_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } rxe_state_t;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  rxe_state_t state_reg;
  logic       take;
  logic       refuse;
  logic [4:0] addr_reg;
  logic [7:0] wdata_reg;
  logic       rd_reg;
  logic       wr_reg;
  logic       valid_reg;
  logic [7:0] data_reg;
  logic       refused_reg;
  logic       irq_reg;
  logic [1:0] rdy_reg;
  logic [1:0] flt_reg;

  assign take   = cmd_valid_i && (state_reg == ST_IDLE);
  assign refuse = take && !cmd_write_i && link_active_i &&
                  (cmd_addr_i == ADDR_REVISION);

  // ==========================================================================
  // Access sequencer
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && !refuse) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link.reg_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg  <= 5'h00;
      wdata_reg <= 8'h00;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
    end else begin
      rd_reg <= take && !refuse && !cmd_write_i;
      wr_reg <= take && !refuse && cmd_write_i;
      if (take) begin
        addr_reg <= cmd_addr_i;
        if (cmd_addr_i == ADDR_BLANK && cmd_wdata_i < BLANK_MIN_MS) begin
          wdata_reg <= BLANK_MIN_MS;
        end else begin
          wdata_reg <= cmd_wdata_i;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_reg   <= 1'b0;
      data_reg    <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      valid_reg   <= (state_reg == ST_WAIT) && link.reg_ack;
      refused_reg <= refuse;
      if ((state_reg == ST_WAIT) && link.reg_ack) begin
        data_reg <= link.reg_rdata;
      end
    end
  end

  // ==========================================================================
  // Event mirrors
  // ==========================================================================
  // service on events
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg <= 1'b0;
      rdy_reg <= '0;
      flt_reg <= '0;
    end else begin
      irq_reg <= link.irq;
      rdy_reg <= link.rdy_pin;
      flt_reg <= link.flt_pin;
    end
  end

  assign cmd_ready_o    = state_reg[0];
  assign rsp_valid_o    = valid_reg;
  assign rsp_data_o     = data_reg;
  assign rsp_refused_o  = refused_reg;
  assign irq_o          = irq_reg;
  assign rx_ready_o     = rdy_reg;
  assign rx_fault_o     = flt_reg;
  assign link.reg_addr  = addr_reg;
  assign link.reg_wdata = wdata_reg;
  assign link.reg_rd    = rd_reg;
  assign link.reg_wr    = wr_reg;

endmodule

// ===== testbench/rxe_link_asserts.sv
// Concurrent checks on the register link and event pins between both ends.
`timescale 1ns/1ps
module rxe_link_asserts
  import rxe_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_ack,
  input  wire logic       irq,
  input  wire logic [1:0] rdy_pin,
  input  wire logic [1:0] flt_pin
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic [3:0] acc_hist_reg;

  // Remembers register strobes of the last four edges.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_hist_reg <= 4'h0;
    end else begin
      acc_hist_reg <= {acc_hist_reg[2:0], reg_rd | reg_wr};
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================================================
  // Sequences and properties
  // ==========================================================================
  sequence s_strobe;
    reg_rd || reg_wr;
  endsequence
  sequence s_rev_read;
    reg_rd && (reg_addr == ADDR_REVISION);
  endsequence
  sequence s_single_ack;
    reg_ack ##1 !reg_ack;
  endsequence

  property p_ack_follows;
    s_strobe |=> s_single_ack;
  endproperty
  property p_no_stray_ack;
    reg_ack |-> $past(reg_rd || reg_wr);
  endproperty
  property p_rev_code;
    s_rev_read |=> reg_ack && (reg_rdata[3:0] == REVISION_CODE);
  endproperty
  property p_rev_upper;
    s_rev_read |=> reg_rdata[7:4] == 4'h0;
  endproperty
  property p_rdata_hold;
    $changed(reg_rdata) |-> reg_ack && $past(reg_rd);
  endproperty
  property p_rdy_clear;
    ($fell(rdy_pin[0]) || $fell(rdy_pin[1])) |-> (acc_hist_reg != 4'h0);
  endproperty
  property p_flt_clear;
    ($fell(flt_pin[0]) || $fell(flt_pin[1])) |-> (acc_hist_reg != 4'h0);
  endproperty
  property p_irq_hold;
    $fell(irq) |-> (acc_hist_reg != 4'h0);
  endproperty

  a_ack_follows: assert property (p_ack_follows)
    else $error("register ack missing one cycle after strobe");
  a_no_stray_ack: assert property (p_no_stray_ack)
    else $error("register ack without strobe");
  a_rev_code: assert property (p_rev_code)
    else $error("revision code wrong");
  a_rev_upper: assert property (p_rev_upper)
    else $error("revision upper bits not zero");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  a_rdy_clear: assert property (p_rdy_clear)
    else $error("ready pin dropped without host access");
  a_flt_clear: assert property (p_flt_clear)
    else $error("fault pin dropped without host access");
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without host access");
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench joining the host and device ends.
`timescale 1ns/1ps
module tb_top
  import rxe_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic            ref_clk_i = 1'b0;
  logic            rstn_i    = 1'b0;
  logic [1:0]      rx_byte_valid_i = 2'h0;
  logic [1:0][7:0] rx_byte_i = '0;
  logic [1:0]      rx_msg_end_i = 2'h0;
  logic [1:0]      rx_msg_err_i = 2'h0;
  logic [1:0]      rx_late_i = 2'h0;
  logic            cmd_valid = 1'b0;
  logic            cmd_write = 1'b0;
  logic [4:0]      cmd_addr = 5'h00;
  logic [7:0]      cmd_wdata = 8'h00;
  logic            link_active = 1'b0;
  logic [1:0]      rx_full;
  logic [7:0]      blank_ms;
  logic            cmd_ready;
  logic            rsp_valid;
  logic [7:0]      rsp_data;
  logic            rsp_refused;
  logic            irq;
  logic [1:0]      rx_ready;
  logic [1:0]      rx_fault;
  int              failures = 0;
  int              tests_run = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  rxe_link_if link_if ();

  rxe_device rxe_device_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .link(link_if), .rx_byte_valid_i(rx_byte_valid_i),
    .rx_byte_i(rx_byte_i), .rx_msg_end_i(rx_msg_end_i),
    .rx_msg_err_i(rx_msg_err_i), .rx_late_i(rx_late_i),
    .rx_full_o(rx_full), .blank_ms_o(blank_ms));

  rxe_host rxe_host_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .link(link_if), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .link_active_i(link_active), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .rsp_refused_o(rsp_refused), .irq_o(irq), .rx_ready_o(rx_ready),
    .rx_fault_o(rx_fault));

  rxe_link_asserts rxe_link_asserts_inst (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_rd(link_if.reg_rd),
    .reg_wr(link_if.reg_wr), .reg_rdata(link_if.reg_rdata),
    .reg_ack(link_if.reg_ack), .irq(link_if.irq),
    .rdy_pin(link_if.rdy_pin), .flt_pin(link_if.flt_pin));

  // ==========================================================================
  // Compare, access and stimulus tasks
  // ==========================================================================
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic access(input logic wr, input logic [4:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output logic refused);
    int n;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr  <= addr;
    cmd_wdata <= wd;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b0;
    for (n = 0; n < 8; n++) begin
      #1;
      if (rsp_valid === 1'b1 || rsp_refused === 1'b1) break;
      @(posedge ref_clk_i);
    end
    if (n == 8) begin
      failures++;
      $display("CHECK FAILED at %0t: no answer", $time);
    end
    rd = rsp_data;
    refused = rsp_refused;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic rd_chk(input logic [4:0] addr, input logic [7:0] exp,
                        input string what);
    logic [7:0] d;
    logic       r;
    access(1'b0, addr, 8'h00, d, r);
    chk8(d, exp, what);
  endtask

  task automatic wr(input logic [4:0] addr, input logic [7:0] data);
    logic [7:0] d;
    logic       r;
    access(1'b1, addr, data, d, r);
  endtask

  task automatic send(input int ch, input int n, input logic [7:0] base,
                      input logic err, input logic late);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      rx_byte_valid_i[ch] <= 1'b1;
      rx_byte_i[ch] <= base + i[7:0];
      rx_msg_end_i[ch] <= (i == n - 1) && !late;
      rx_msg_err_i[ch] <= err;
    end
    @(posedge ref_clk_i);
    rx_byte_valid_i <= 2'h0;
    rx_msg_end_i <= 2'h0;
    rx_msg_err_i <= 2'h0;
    rx_late_i[ch] <= late;
    @(posedge ref_clk_i);
    rx_late_i <= 2'h0;
    repeat (4) @(posedge ref_clk_i);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_init;
    rd_chk(ADDR_REVISION, {4'h0, REVISION_CODE}, "revision");
    rd_chk(ADDR_REVISION, {4'h0, REVISION_CODE}, "revision again");
    rd_chk(5'h1e, 8'h00, "unmapped");
    rd_chk(ADDR_EVENT, 8'h00, "events idle");
    chk8(blank_ms, BLANK_RESET, "blank reset");
    chk1(irq, 1'b0, "no service idle");
    chk1(cmd_ready, 1'b1, "host idle");
    $display("test init done");
  endtask

  task automatic t_refuse;
    logic [7:0] d;
    logic       r;
    link_active <= 1'b1;
    access(1'b0, ADDR_REVISION, 8'h00, d, r);
    chk1(r, 1'b1, "refused");
    link_active <= 1'b0;
    $display("test refuse done");
  endtask

  task automatic t_ready;
    wr(ADDR_IRQ_EN, 8'h0f);
    wr(ADDR_PIN_EN, 8'h0f);
    send(0, 2, 8'ha1, 1'b0, 1'b0);
    chk1(irq, 1'b1, "irq on ready");
    chk1(rx_ready[0], 1'b1, "ready pin");
    rd_chk(ADDR_EVENT, 8'h01, "ready flag");
    rd_chk(ADDR_QUEUE_A, 8'ha1, "byte one");
    chk1(irq, 1'b1, "irq held");
    rd_chk(ADDR_QUEUE_A, 8'ha2, "byte two");
    chk1(rx_ready[0], 1'b0, "ready pin cleared");
    chk1(irq, 1'b0, "irq cleared");
    $display("test ready done");
  endtask

  task automatic t_fault;
    wr(ADDR_IRQ_EN, 8'h03);
    send(1, 2, 8'hb1, 1'b1, 1'b0);
    chk1(rx_fault[1], 1'b1, "fault pin");
    chk1(irq, 1'b0, "fault masked");
    rd_chk(ADDR_EVENT, 8'h08, "fault flag");
    rd_chk(ADDR_EVENT, 8'h00, "fault cleared");
    rd_chk(ADDR_LEVEL_B, 8'h02, "kept bytes");
    rd_chk(ADDR_QUEUE_B, 8'hb1, "kept one");
    rd_chk(ADDR_QUEUE_B, 8'hb2, "kept two");
    $display("test fault done");
  endtask

  task automatic t_discard;
    wr(ADDR_IRQ_EN, 8'h0f);
    wr(ADDR_CFG, 8'h01);
    send(0, 1, 8'hc1, 1'b0, 1'b1);
    chk1(irq, 1'b1, "irq on late");
    chk1(rx_fault[0], 1'b1, "late pin");
    rd_chk(ADDR_LEVEL_A, 8'h00, "late dropped");
    rd_chk(ADDR_EVENT, 8'h04, "late flag");
    chk1(irq, 1'b0, "irq after clear");
    send(0, 2, 8'hd1, 1'b1, 1'b0);
    rd_chk(ADDR_LEVEL_A, 8'h00, "bad dropped");
    rd_chk(ADDR_EVENT, 8'h04, "bad flag");
    $display("test discard done");
  endtask

  task automatic t_full;
    send(1, 17, 8'he0, 1'b0, 1'b0);
    chk1(rx_full[1], 1'b1, "queue full");
    chk1(rx_ready[1], 1'b1, "full ready pin");
    rd_chk(ADDR_LEVEL_B, {3'h0, QUEUE_DEPTH}, "full level");
    for (int i = 0; i < 16; i++) begin
      rd_chk(ADDR_QUEUE_B, 8'he0 + i[7:0], "full drain");
    end
    chk1(rx_full[1], 1'b0, "queue drained");
    chk1(rx_ready[1], 1'b0, "drained pin");
    chk1(irq, 1'b0, "drained irq");
    $display("test full done");
  endtask

  task automatic t_blank;
    wr(ADDR_BLANK, 8'h10);
    rd_chk(ADDR_BLANK, BLANK_MIN_MS, "blank clamp");
    wr(ADDR_BLANK, 8'h64);
    chk8(blank_ms, 8'h64, "blank set");
    $display("test blank done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_init();
    t_refuse();
    t_ready();
    t_fault();
    t_discard();
    t_full();
    t_blank();
    report_and_stop();
  end

  initial begin
    #125000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    report_and_stop();
  end
endmodule
